/* File: pioba_pkg.sv */
// constants for the parallel io bus host adapter
package pioba_pkg;
	localparam int unsigned MCLK_HZ = 200_000_000;
	localparam int unsigned MCLK_NS = 5;
	// register offsets
	localparam logic [3:0] OFS_RESET = 4'h0;
	localparam logic [3:0] OFS_BANK = 4'h1;
	localparam logic [3:0] OFS_DATA = 4'h2;
	localparam logic [3:0] OFS_TRIG = 4'h3;
	localparam logic [3:0] OFS_STATE = 4'h4;
	localparam logic [3:0] OFS_OPTION = 4'h5;
	localparam logic [3:0] OFS_REV = 4'h6;
	localparam logic [7:0] TRIG_READ_VALUE = 8'hAB;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
	// field positions
	localparam int unsigned RST_LEVEL_BIT = 0;
	localparam int unsigned RST_BUSY_BIT = 7;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_WRITE_BIT = 5;
	localparam int unsigned ST_READ_BIT = 6;
	localparam int unsigned OPT_STROBE_BIT = 4;
	localparam int unsigned OPT_IDLE_BIT = 5;
	localparam logic RESET_LEVEL_INIT = 1'b0;
	// timing, printed figures and derived cycle counts
	localparam int unsigned HOLD_MS = 150;
	localparam int unsigned HOLD_CYCLES = HOLD_MS * (MCLK_HZ / 1000);
	localparam int unsigned STROBE_SHORT_NS = 2700;
	localparam int unsigned STROBE_LONG_NS = 3300;
	localparam int unsigned IDLE_GAP_NS = 3600;
	localparam int unsigned SETUP_NS = 100;
	localparam logic [11:0] STROBE_SHORT_CYC = 12'((STROBE_SHORT_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [11:0] STROBE_LONG_CYC = 12'((STROBE_LONG_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [11:0] IDLE_GAP_CYC = 12'((IDLE_GAP_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [11:0] SETUP_CYC = 12'((SETUP_NS + MCLK_NS - 1) / MCLK_NS);
	typedef enum logic [2:0] {PB_IDLE, PB_SETUP, PB_STROBE, PB_GAP} pioba_phase_t;
endpackage : pioba_pkg

/* File: pioba_hold_timer.sv */
// restartable reset-hold timer
`timescale 1ns/1ps
module pioba_hold_timer
	import pioba_pkg::*;
#(
	parameter int unsigned HOLD_COUNT = HOLD_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control and status
	input wire logic restart,
	output logic running
);
	logic [27:0] count;
	wire logic at_end = (count == 28'h000_0001);

	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= 28'h000_0000;
			running <= 1'b0;
		end else if (restart) begin
			count <= 28'(HOLD_COUNT);
			running <= 1'b1;
		end else if (running) begin
			count <= count - 28'h000_0001;
			running <= !at_end;
		end
	end

	a_hold_restart: assert property (@(posedge mclk) disable iff (rst)
		restart |=> running)
		else $error("hold flag not set on restart");
	a_hold_clear: assert property (@(posedge mclk) disable iff (rst)
		$fell(running) |-> $past(count) == 28'h000_0001)
		else $error("hold flag fell early");
endmodule : pioba_hold_timer

/* File: pioba_adapter.sv */
// register window and bus cycle engine of the parallel io bus host adapter
`timescale 1ns/1ps
// Operation
// - sixteen byte locations in the window, only the lowest seven are defined.
// - offset zero reads reset level in bit 0, hold timer flag in bit 7.
// - each reset control write restarts the 150 ms timer and sets its flag.
// - written bit 0 drives the reset line at once: one low, zero high.
// - bank location keeps six address bits, used by the next bus cycle.
// - data location supplies write byte and holds the byte read back.
// - reading offset three starts a bus read and returns 0xAB.
// - writing offset three starts a bus write, value ignored.
// - status bit 0 reads one while a bus cycle runs.
// - status bits 2..1 catch the identity of the last brain accessed.
// - status bit 5 marks a write, bit 6 a read, bits 4..3 zero.
// - offset five returns the six option inputs, upper bits zero.
// - offset six returns the version byte without side effects.
// - after power-up reset bit and status flags are zero.
// - reset lamp lit while the reset line is high.
// - identity via standard vendor and device fields, comms class.
// - option five picks strobe width 2.7 or 3.3 microseconds.
// - option six zero adds idle time, busy held during it.
module pioba_adapter
	import pioba_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = 16'h1234, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h5678, // arbitrary value
	parameter logic [7:0] REVISION_BYTE = 8'h01, // arbitrary value
	parameter int unsigned HOLD_COUNT = HOLD_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register window from the endpoint core
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// identity presented to the endpoint configuration space
	output logic [15:0] vendor_id,
	output logic [15:0] device_id,
	output logic [23:0] class_code,
	// option switches, asynchronous, sampled on mclk through two flops
	input wire logic [5:0] option_pins,
	// parallel bus
	output logic [5:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe_n,
	output logic bus_read_strobe,
	output logic bus_write_strobe,
	input wire logic brain_ident_high,
	input wire logic brain_ident_low,
	output logic bus_reset_line,
	// indicators
	output logic reset_indicator_lamp
);
	localparam logic [23:0] COMMS_CLASS = 24'h07_0000;

	pioba_phase_t phase;
	pioba_phase_t next_phase;
	logic [11:0] timer;
	logic [11:0] next_timer;
	logic reset_level;
	logic [5:0] bank_select;
	logic [7:0] transfer_byte;
	logic cyc_write;
	logic cyc_read;
	logic [1:0] ident;
	logic [5:0] opt_meta;
	logic [5:0] option_inputs;
	logic [1:0] id_meta;
	logic [1:0] id_sync;
	logic [7:0] data_meta;
	logic [7:0] data_sync;
	logic hold_running;

	// decode of the window
	wire logic sel_reset = (reg_addr == OFS_RESET);
	wire logic sel_bank = (reg_addr == OFS_BANK);
	wire logic sel_data = (reg_addr == OFS_DATA);
	wire logic sel_trig = (reg_addr == OFS_TRIG);
	wire logic wr_reset = reg_wr && sel_reset;
	wire logic start_read = reg_rd && sel_trig && (phase == PB_IDLE);
	wire logic start_write = reg_wr && sel_trig && (phase == PB_IDLE);
	wire logic busy = (phase != PB_IDLE);
	wire logic [11:0] strobe_len = option_inputs[OPT_STROBE_BIT] ?
		STROBE_LONG_CYC : STROBE_SHORT_CYC;
	wire logic timer_done = (timer == 12'h000);
	wire logic [7:0] reset_view = {hold_running, 6'h00, reset_level};
	wire logic [7:0] state_view = {1'b0, cyc_read, cyc_write, 2'b00, ident, busy};
	wire logic [7:0] option_view = {2'b00, option_inputs};
	// pin and lamp take the new level on the same edge that stores it
	wire logic next_reset_level = wr_reset ? reg_wdata[RST_LEVEL_BIT] : reset_level;

	logic [7:0] read_mux;
	always_comb begin
		case (reg_addr)
			OFS_RESET: read_mux = reset_view;
			OFS_BANK: read_mux = {2'b00, bank_select};
			OFS_DATA: read_mux = transfer_byte;
			OFS_TRIG: read_mux = TRIG_READ_VALUE;
			OFS_STATE: read_mux = state_view;
			OFS_OPTION: read_mux = option_view;
			OFS_REV: read_mux = REVISION_BYTE;
			default: read_mux = UNMAPPED_VALUE;
		endcase
	end

	// bus cycle sequencer
	always_comb begin
		next_phase = phase;
		next_timer = timer;
		case (phase)
			PB_IDLE: begin
				if (start_read || start_write) begin
					next_phase = PB_SETUP;
					next_timer = SETUP_CYC - 12'h001;
				end
			end
			PB_SETUP: begin
				if (timer_done) begin
					next_phase = PB_STROBE;
					next_timer = strobe_len - 12'h001;
				end else begin
					next_timer = timer - 12'h001;
				end
			end
			PB_STROBE: begin
				if (timer_done) begin
					// low latency mode skips the extra idle time
					if (!option_inputs[OPT_IDLE_BIT]) begin
						next_phase = PB_GAP;
						next_timer = IDLE_GAP_CYC - 12'h001;
					end else begin
						next_phase = PB_IDLE;
					end
				end else begin
					next_timer = timer - 12'h001;
				end
			end
			PB_GAP: begin
				if (timer_done) begin
					next_phase = PB_IDLE;
				end else begin
					next_timer = timer - 12'h001;
				end
			end
			default: begin
				next_phase = PB_IDLE;
				next_timer = 12'h000;
			end
		endcase
	end
	wire logic strobe_end = (phase == PB_STROBE) && timer_done;

	always_ff @(posedge mclk) begin
		if (rst) begin
			phase <= PB_IDLE;
			timer <= 12'h000;
		end else begin
			phase <= next_phase;
			timer <= next_timer;
		end
	end

	// synchronisers for asynchronous inputs
	always_ff @(posedge mclk) begin
		opt_meta <= option_pins;
		option_inputs <= opt_meta;
		id_meta <= {brain_ident_high, brain_ident_low};
		id_sync <= id_meta;
		data_meta <= bus_data_in;
		data_sync <= data_meta;
	end

	// software state
	always_ff @(posedge mclk) begin
		if (rst) begin
			reset_level <= RESET_LEVEL_INIT;
			bank_select <= 6'h00;
		end else begin
			if (wr_reset) begin
				reset_level <= reg_wdata[RST_LEVEL_BIT];
			end
			// writes during a cycle are dropped so the bus address stays stable
			if (reg_wr && sel_bank && !busy) begin
				bank_select <= reg_wdata[5:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			transfer_byte <= 8'h00;
			ident <= 2'b00;
		end else if (strobe_end) begin
			ident <= id_sync;
			if (cyc_read) begin
				transfer_byte <= data_sync;
			end
		end else if (reg_wr && sel_data && !busy) begin
			transfer_byte <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cyc_read <= 1'b0;
			cyc_write <= 1'b0;
		end else if (start_read || start_write) begin
			cyc_read <= start_read;
			cyc_write <= start_write;
		end
	end

	// registered outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			bus_addr <= 6'h00;
			bus_data_out <= 8'h00;
			bus_data_oe_n <= 1'b1;
			bus_read_strobe <= 1'b0;
			bus_write_strobe <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? read_mux : 8'h00;
			bus_addr <= bank_select;
			bus_data_out <= transfer_byte;
			bus_data_oe_n <= !(busy && cyc_write && !start_read);
			bus_read_strobe <= (next_phase == PB_STROBE) && cyc_read;
			bus_write_strobe <= (next_phase == PB_STROBE) && cyc_write;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_reset_line <= 1'b1;
			reset_indicator_lamp <= 1'b1;
			vendor_id <= 16'h0000;
			device_id <= 16'h0000;
			class_code <= 24'h00_0000;
		end else begin
			bus_reset_line <= !next_reset_level;
			reset_indicator_lamp <= !next_reset_level;
			vendor_id <= VENDOR_CODE;
			device_id <= DEVICE_CODE;
			class_code <= COMMS_CLASS;
		end
	end

	pioba_hold_timer #(
		.HOLD_COUNT(HOLD_COUNT)
	) u_pioba_hold_timer (
		.mclk(mclk),
		.rst(rst),
		.restart(wr_reset),
		.running(hold_running)
	);

	a_reset_line: assert property (@(posedge mclk) disable iff (rst)
		wr_reset |=> bus_reset_line == !$past(reg_wdata[0]))
		else $error("reset line wrong");
	a_lamp_follows: assert property (@(posedge mclk) disable iff (rst)
		reset_indicator_lamp == bus_reset_line)
		else $error("lamp off line");
	a_busy_start: assert property (@(posedge mclk) disable iff (rst)
		(start_read || start_write) |=> busy)
		else $error("no busy after start");
	a_read_const: assert property (@(posedge mclk) disable iff (rst)
		(reg_rd && sel_trig) |=> reg_rdata == 8'hAB)
		else $error("trigger read wrong");
	a_dir_flags: assert property (@(posedge mclk) disable iff (rst)
		start_write |=> cyc_write && !cyc_read)
		else $error("write flag wrong");
	a_strobe_dir: assert property (@(posedge mclk) disable iff (rst)
		!(bus_read_strobe && bus_write_strobe))
		else $error("both strobes");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr > OFS_REV) |=> reg_rdata == 8'h00)
		else $error("unmapped read");
	a_gap_busy: assert property (@(posedge mclk) disable iff (rst)
		(strobe_end && !option_inputs[OPT_IDLE_BIT]) |=> busy [*8])
		else $error("idle gap too short");
	a_strobe_width: assert property (@(posedge mclk) disable iff (rst)
		$rose(bus_read_strobe) && !option_inputs[OPT_STROBE_BIT] |-> bus_read_strobe [*8])
		else $error("strobe too short");
	a_write_width: assert property (@(posedge mclk) disable iff (rst)
		$rose(bus_write_strobe) && option_inputs[OPT_STROBE_BIT] |-> bus_write_strobe [*8])
		else $error("write strobe too short");
	a_write_drive: assert property (@(posedge mclk) disable iff (rst)
		bus_write_strobe |-> !bus_data_oe_n)
		else $error("write strobe without data drive");
	a_read_latch: assert property (@(posedge mclk) disable iff (rst)
		(strobe_end && cyc_read) |=> transfer_byte == $past(data_sync))
		else $error("read byte lost");
	a_ident_latch: assert property (@(posedge mclk) disable iff (rst)
		strobe_end |=> ident == $past(id_sync))
		else $error("brain identity lost");
	a_bank_busy: assert property (@(posedge mclk) disable iff (rst)
		(busy && reg_wr && sel_bank) |=> $stable(bank_select))
		else $error("bank moved during cycle");
	c_read_cycle: cover property (@(posedge mclk) disable iff (rst) strobe_end && cyc_read);
	c_write_cycle: cover property (@(posedge mclk) disable iff (rst) start_write ##[1:1000] !busy);
	c_reset_write: cover property (@(posedge mclk) disable iff (rst) wr_reset ##1 hold_running);
	c_gap_mode: cover property (@(posedge mclk) disable iff (rst)
		strobe_end && !option_inputs[OPT_IDLE_BIT]);
endmodule : pioba_adapter

/* File: pioba_brain_model.sv */
// behavioural brain boards on the far side of the parallel bus
`timescale 1ns/1ps
module pioba_brain_model (
	// clock
	input wire logic mclk,
	// bus from the adapter
	input wire logic [5:0] bus_addr,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe_n,
	input wire logic bus_read_strobe,
	input wire logic bus_write_strobe,
	// bus to the adapter
	output logic [7:0] bus_data_in,
	output logic brain_ident_high,
	output logic brain_ident_low,
	// last write seen, for the bench
	output logic [5:0] wr_addr,
	output logic [7:0] wr_data,
	output logic oe_ok
);
	logic [7:0] noise = 8'h5A;
	logic wr_prev = 1'b0;
	logic [5:0] last_addr = 6'h00;
	logic [7:0] last_data = 8'h00;
	logic drive_ok = 1'b1;
	wire strobe = bus_read_strobe | bus_write_strobe;
	// unselected lines wander every cycle so a stale latch shows up
	always @(posedge mclk) begin
		noise <= {noise[6:0], ~noise[7]};
		wr_prev <= bus_write_strobe;
		if (bus_write_strobe && bus_data_oe_n)
			drive_ok <= 1'b0;
		if (wr_prev && !bus_write_strobe) begin
			last_addr <= bus_addr;
			last_data <= bus_data_out;
		end
	end
	assign wr_addr = last_addr;
	assign wr_data = last_data;
	assign oe_ok = drive_ok;
	assign bus_data_in = bus_read_strobe ? {2'b11, bus_addr} : noise;
	assign brain_ident_high = strobe ? bus_addr[1] : noise[0];
	assign brain_ident_low = strobe ? bus_addr[0] : noise[3];
endmodule : pioba_brain_model

/* File: test_pioba_adapter.sv */
// self-checking bench of the parallel io bus host adapter
`timescale 1ns/1ps
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_pioba_adapter;
	import pioba_pkg::*;
	localparam int unsigned HOLD = 50;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic reg_rd = 1'b0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [5:0] option_pins = 6'h30;
	logic [7:0] reg_rdata, bus_data_in, bus_data_out, wr_data;
	logic [15:0] vendor_id, device_id;
	logic [23:0] class_code;
	logic [5:0] bus_addr, wr_addr;
	logic bus_data_oe_n, bus_read_strobe, bus_write_strobe, brain_ident_high, brain_ident_low;
	logic bus_reset_line, reset_indicator_lamp, oe_ok;
	logic [11:0] rd_len = 12'h000;
	logic [11:0] wr_len = 12'h000;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	always #2.5 mclk = ~mclk;
	pioba_adapter #(.HOLD_COUNT(HOLD)) u_pioba_adapter (.mclk(mclk), .rst(rst),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .vendor_id(vendor_id), .device_id(device_id),
		.class_code(class_code), .option_pins(option_pins), .bus_addr(bus_addr),
		.bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
		.bus_read_strobe(bus_read_strobe), .bus_write_strobe(bus_write_strobe),
		.brain_ident_high(brain_ident_high), .brain_ident_low(brain_ident_low),
		.bus_reset_line(bus_reset_line), .reset_indicator_lamp(reset_indicator_lamp));
	pioba_brain_model u_pioba_brain_model (.mclk(mclk), .bus_addr(bus_addr),
		.bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
		.bus_read_strobe(bus_read_strobe), .bus_write_strobe(bus_write_strobe),
		.bus_data_in(bus_data_in), .brain_ident_high(brain_ident_high),
		.brain_ident_low(brain_ident_low), .wr_addr(wr_addr), .wr_data(wr_data), .oe_ok(oe_ok));
	always @(posedge mclk) begin
		if (bus_read_strobe === 1'b1)
			rd_len <= rd_len + 12'h001;
		if (bus_write_strobe === 1'b1)
			wr_len <= wr_len + 12'h001;
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1 reg_wr = 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
	endtask : reg_read
	// polls status only; data and trigger stay untouched while busy
	task automatic wait_idle(output int n, output logic [7:0] s);
		n = 0;
		do begin
			reg_read(OFS_STATE, s);
			n += 2;
		end while (s[0] !== 1'b0 && n < 4000);
		`CHECK(s[0], 1'b0)
	endtask : wait_idle
	task automatic test_power_up();
		logic [7:0] d;
		reg_read(OFS_RESET, d);
		`CHECK(d, 8'h00)
		`CHECK(bus_reset_line, 1'b1)
		`CHECK(reset_indicator_lamp, 1'b1)
		reg_read(OFS_STATE, d);
		`CHECK(d & 8'h79, 8'h00)
		`CHECK(class_code, 24'h07_0000)
		`CHECK(vendor_id, 16'h1234)
		`CHECK(device_id, 16'h5678)
	endtask : test_power_up
	task automatic test_reset_hold();
		logic [7:0] d;
		reg_write(OFS_RESET, 8'h01);
		repeat (2) @(posedge mclk);
		`CHECK(bus_reset_line, 1'b0)
		`CHECK(reset_indicator_lamp, 1'b0)
		reg_read(OFS_RESET, d);
		`CHECK(d, 8'h81)
		repeat (24) @(posedge mclk);
		reg_write(OFS_RESET, 8'hFF);
		repeat (40) @(posedge mclk);
		reg_read(OFS_RESET, d);
		`CHECK(d, 8'h81)
		repeat (20) @(posedge mclk);
		reg_read(OFS_RESET, d);
		`CHECK(d, 8'h01)
		reg_write(OFS_RESET, 8'hFE);
		repeat (2) @(posedge mclk);
		`CHECK(bus_reset_line, 1'b1)
		`CHECK(reset_indicator_lamp, 1'b1)
	endtask : test_reset_hold
	task automatic test_write_cycle();
		logic [7:0] d;
		int n;
		logic [11:0] w0;
		logic [11:0] r0;
		reg_write(OFS_BANK, 8'h2A);
		reg_write(OFS_DATA, 8'h5C);
		reg_read(OFS_BANK, d);
		`CHECK(d & 8'h3F, 8'h2A)
		w0 = wr_len;
		r0 = rd_len;
		reg_write(OFS_TRIG, 8'h77);
		reg_read(OFS_STATE, d);
		`CHECK(d & 8'h79, 8'h21)
		wait_idle(n, d);
		`CHECK(d & 8'h7F, 8'h24)
		`CHECK(wr_len - w0, STROBE_LONG_CYC)
		`CHECK(rd_len - r0, 12'h000)
		`CHECK(n < int'(SETUP_CYC + STROBE_LONG_CYC + IDLE_GAP_CYC / 2), 1'b1)
		`CHECK(wr_addr, 6'h2A)
		`CHECK(wr_data, 8'h5C)
		`CHECK(oe_ok, 1'b1)
	endtask : test_write_cycle
	task automatic test_read_cycle();
		logic [7:0] d;
		int n;
		logic [11:0] r0;
		option_pins = 6'h00;
		reg_write(OFS_BANK, 8'h15);
		r0 = rd_len;
		reg_read(OFS_TRIG, d);
		`CHECK(d, TRIG_READ_VALUE)
		reg_read(OFS_REV, d);
		`CHECK(d, 8'h01)
		reg_read(OFS_STATE, d);
		`CHECK(d & 8'h79, 8'h41)
		wait_idle(n, d);
		`CHECK(d & 8'h7F, 8'h42)
		`CHECK(rd_len - r0, STROBE_SHORT_CYC)
		// polling starts four cycles after the trigger edge
		`CHECK(n + 4 >= int'(SETUP_CYC + STROBE_SHORT_CYC + IDLE_GAP_CYC), 1'b1)
		reg_read(OFS_DATA, d);
		`CHECK(d, 8'hD5)
	endtask : test_read_cycle
	task automatic test_options_unmapped();
		logic [7:0] d;
		option_pins = 6'h2D;
		repeat (4) @(posedge mclk);
		reg_read(OFS_OPTION, d);
		`CHECK(d, 8'h2D)
		for (int a = 7; a < 16; a++) begin
			reg_write(4'(a), 8'hFF);
			reg_read(4'(a), d);
			`CHECK(d, UNMAPPED_VALUE)
		end
		reg_read(OFS_BANK, d);
		`CHECK(d & 8'h3F, 8'h15)
		`CHECK(bus_reset_line, 1'b1)
	endtask : test_options_unmapped
	initial begin
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		test_power_up();
		test_reset_hold();
		test_write_cycle();
		test_read_cycle();
		test_options_unmapped();
		give_verdict();
	end
endmodule : test_pioba_adapter
